//--- design/sync_off_pin.sv
`timescale 1ns/100ps

module sync_off_pin
	import sync_off_pkg::*;
#(
	parameter int PULSE_CYC = PULSE_LOW_CYC
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sw_on,
	input wire logic sw_off,
	output logic input_on,
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] PULSE_N = CNT_W'(PULSE_CYC);

	st_t s_q;
	st_t s_d;
	logic pwm_lvl;
	logic act_lvl;
	logic rx_act;
	logic rx_hit;

	sync_pwm_gen u_pwm (
		.sys_clk(sys_clk),
		.srst(srst),
		.en(s_q.cfg.func == FN_OUT && s_q.cfg.omode == OM_PWM),
		.per(s_q.cfg.pwm_per),
		.hi(s_q.cfg.pwm_hi),
		.lvl(pwm_lvl)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Active pin level is low unless inverted
		act_lvl = s_q.cfg.inv;
		// Own pulse is masked so it cannot turn us off
		rx_act = (s_q.pin_s == act_lvl) && !s_q.pin_oe
			&& s_q.cfg.func == FN_SYNC;
		rx_hit = rx_act && (s_q.rx_cnt == PULSE_N - 16'h0001);

		s_d.meta = pin_i;
		s_d.pin_s = s_q.meta;

		if (!rx_act) begin
			s_d.rx_cnt = '0;
		end else if (s_q.rx_cnt != PULSE_N) begin
			s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
		end

		// Off wins over on; a pulse while off is ignored
		if (sw_off || (rx_hit && s_q.on)) begin
			s_d.on = 1'b0;
		end else if (sw_on) begin
			s_d.on = 1'b1;
		end

		if (s_q.cfg.func != FN_SYNC) begin
			s_d.tx_cnt = '0;
		end else if (s_q.on && !s_d.on) begin
			s_d.tx_cnt = PULSE_N;
		end else if (s_q.tx_cnt != '0) begin
			s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
		end

		s_d.pin_oe = 1'b0;
		s_d.pin_o = !act_lvl;
		unique case (s_q.cfg.func)
			FN_SYNC: begin
				s_d.pin_oe = s_d.tx_cnt != '0;
				s_d.pin_o = act_lvl;
			end
			FN_IN: begin
				s_d.pin_oe = 1'b0;
			end
			FN_OUT: begin
				s_d.pin_oe = 1'b1;
				unique case (s_q.cfg.omode)
					OM_TRUE: s_d.pin_o = act_lvl;
					OM_FALSE: s_d.pin_o = !act_lvl;
					OM_PWM: s_d.pin_o = pwm_lvl ~^ act_lvl;
					default: s_d.pin_o = !act_lvl;
				endcase
			end
			default: s_d.pin_oe = 1'b0;
		endcase

		// --------------------------------------------------------
		// Register port
		// --------------------------------------------------------
		s_d.rdata = '0;
		if (wr) begin
			unique case (addr)
				OFS_CTRL: begin
					// Illegal mode codes are dropped, keeping the old mode
					if (is_onehot3(wdata[CTRL_FUNC_LSB +: 3])) begin
						s_d.cfg.func = func_t'(wdata[CTRL_FUNC_LSB +: 3]);
					end
					s_d.cfg.inv = wdata[CTRL_INV_BIT];
					if (is_onehot3(wdata[CTRL_OMODE_LSB +: 3])) begin
						s_d.cfg.omode = omode_t'(wdata[CTRL_OMODE_LSB +: 3]);
					end
				end
				OFS_PWM_PER: s_d.cfg.pwm_per = wdata[PWM_W-1:0];
				OFS_PWM_HI: s_d.cfg.pwm_hi = wdata[PWM_W-1:0];
				default: s_d.cfg = s_q.cfg;
			endcase
		end
		if (rd) begin
			unique case (addr)
				OFS_CTRL: s_d.rdata = {25'h0000000, s_q.cfg.omode,
					s_q.cfg.inv, s_q.cfg.func};
				OFS_PWM_PER: s_d.rdata = {8'h00, s_q.cfg.pwm_per};
				OFS_PWM_HI: s_d.rdata = {8'h00, s_q.cfg.pwm_hi};
				OFS_STATUS: s_d.rdata = {28'h0000000, s_q.tx_cnt != '0,
					rx_act, s_q.pin_s, s_q.on};
				default: s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q <= '{cfg: '{func: FUNC_RST, inv: INV_RST, omode: OMODE_RST,
				pwm_per: PWM_PER_RST, pwm_hi: PWM_HI_RST},
				meta: 1'b1, pin_s: 1'b1, on: 1'b0, tx_cnt: '0, rx_cnt: '0,
				pin_o: 1'b1, pin_oe: 1'b0, rdata: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign input_on = s_q.on;
	assign pin_o = s_q.pin_o;
	assign pin_oe = s_q.pin_oe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	logic [CNT_W-1:0] drv_len;
	always_ff @(posedge sys_clk) begin
		if (srst || !pin_oe) begin
			drv_len <= '0;
		end else if (drv_len != 16'hffff) begin
			drv_len <= drv_len + 16'h0001;
		end
	end

	sequence s_sync_off_edge;
		s_q.cfg.func == FN_SYNC ##1 $fell(s_q.on);
	endsequence

	sequence s_rx_full;
		rx_hit ##0 s_q.on;
	endsequence

	AST_INV_PULSE: assert property (
		pin_oe && $past(s_q.cfg.func) == FN_SYNC && $stable(s_q.cfg.inv)
		|-> pin_o == s_q.cfg.inv)
		else $error("sync pulse level ignores polarity");

	AST_SYNC_RELEASE: assert property (
		s_q.cfg.func == FN_SYNC && $stable(s_q.cfg.func)
		|-> pin_oe == (s_q.tx_cnt != '0))
		else $error("sync pin driven outside a pulse");

	AST_OFF_PULSE: assert property (
		s_sync_off_edge |-> pin_oe && s_q.tx_cnt == PULSE_N)
		else $error("no pulse after switch went off");

	AST_IGNORE_OFF: assert property (
		rx_hit && !s_q.on && !sw_on |=> !s_q.on)
		else $error("pulse while off changed the switch");

	AST_RX_OFF: assert property (
		s_rx_full |=> !s_q.on ##0 pin_oe)
		else $error("received pulse did not turn the switch off");

	AST_TX_WIDTH: assert property (
		$fell(pin_oe) && $past(s_q.cfg.func, 2) == FN_SYNC
		&& $past(s_q.cfg.func) == FN_SYNC
		|-> $past(drv_len) >= PULSE_N - 16'h0001)
		else $error("sent pulse shorter than the least width");

	AST_TRUE_LVL: assert property (
		s_q.cfg.func == FN_OUT && s_q.cfg.omode == OM_TRUE
		|=> pin_oe && pin_o == $past(s_q.cfg.inv))
		else $error("true output at wrong level");

	AST_FALSE_LVL: assert property (
		s_q.cfg.func == FN_OUT && s_q.cfg.omode == OM_FALSE
		|=> pin_oe && pin_o == !$past(s_q.cfg.inv))
		else $error("false output at wrong level");

	AST_PWM_LVL: assert property (
		s_q.cfg.func == FN_OUT && s_q.cfg.omode == OM_PWM
		|=> pin_o == ($past(pwm_lvl) ~^ $past(s_q.cfg.inv)))
		else $error("pwm output does not follow the generator");

endmodule

//--- design/sync_off_pwm.sv
`timescale 1ns/100ps

package sync_off_pkg;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PWM_PER = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_PWM_HI = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;
	localparam int CTRL_FUNC_LSB = 0;
	localparam int CTRL_INV_BIT = 3;
	localparam int CTRL_OMODE_LSB = 4;
	localparam int PWM_W = 24;

	// ------------------------------------------------------------
	// Modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FN_SYNC = 3'h1,
		FN_IN = 3'h2,
		FN_OUT = 3'h4
	} func_t;

	typedef enum logic [2:0] {
		OM_TRUE = 3'h1,
		OM_FALSE = 3'h2,
		OM_PWM = 3'h4
	} omode_t;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam func_t FUNC_RST = FN_SYNC;
	localparam logic INV_RST = 1'h0;
	localparam omode_t OMODE_RST = OM_TRUE;
	localparam logic [PWM_W-1:0] PWM_PER_RST = 24'h0000c8;
	localparam logic [PWM_W-1:0] PWM_HI_RST = 24'h000064;
	localparam int CLK_PERIOD_NS = 5;
	localparam int PULSE_LOW_MIN_NS = 30000;
	// Least time, so round up
	localparam int PULSE_LOW_CYC =
		(PULSE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	// ------------------------------------------------------------
	// State carriers
	// ------------------------------------------------------------
	typedef struct packed {
		func_t func;
		logic inv;
		omode_t omode;
		logic [PWM_W-1:0] pwm_per;
		logic [PWM_W-1:0] pwm_hi;
	} cfg_t;

	typedef struct packed {
		logic [PWM_W-1:0] cnt;
		logic lvl;
	} pwm_st_t;

	typedef struct packed {
		cfg_t cfg;
		logic meta;
		logic pin_s;
		logic on;
		logic [CNT_W-1:0] tx_cnt;
		logic [CNT_W-1:0] rx_cnt;
		logic pin_o;
		logic pin_oe;
		logic [31:0] rdata;
	} st_t;

	function automatic logic is_onehot3(input logic [2:0] v);
		return (v == 3'h1) || (v == 3'h2) || (v == 3'h4);
	endfunction

endpackage

module sync_pwm_gen
	import sync_off_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic en,
	input wire logic [PWM_W-1:0] per,
	input wire logic [PWM_W-1:0] hi,
	output logic lvl
);

	pwm_st_t s_q;
	pwm_st_t s_d;

	// Period in cycles is per (0 treated as 1), high time is hi
	always_comb begin
		s_d = s_q;
		if (!en || s_q.cnt + 24'h000001 >= per) begin
			s_d.cnt = '0;
		end else begin
			s_d.cnt = s_q.cnt + 24'h000001;
		end
		s_d.lvl = en && (s_d.cnt < hi);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lvl = s_q.lvl;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	AST_PWM_WRAP: assert property (
		en && $stable(per) && s_q.cnt + 24'h000001 >= per |=> s_q.cnt == '0)
		else $error("pwm counter did not wrap at period");

endmodule

//--- dv/sync_peer.sv
`timescale 1ns/100ps
module sync_peer (
	input wire logic sys_clk,
	input wire logic line,
	input wire logic go,
	input wire logic [7:0] len,
	output logic drv_oe,
	output logic [7:0] seen_q
);
	logic [7:0] left_q = 8'h0;
	logic [7:0] run_q = 8'h0;
	assign drv_oe = left_q != 8'h0;
	initial seen_q = 8'h0;
	always @(posedge sys_clk) begin
		// Holds the line low for len cycles
		if (go)
			left_q <= len;
		else if (drv_oe)
			left_q <= left_q - 8'h1;
		// Width of the last low phase sent by the far end
		run_q <= (!line && !drv_oe) ? run_q + 8'h1 : 8'h0;
		if (line && run_q != 8'h0)
			seen_q <= run_q;
	end
endmodule

//--- dv/sync_off_pin_test.sv
`timescale 1ns/100ps
module sync_off_pin_test
	import sync_off_pkg::*;
;
	localparam int PC = 8;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sw_on = 1'b0;
	logic sw_off = 1'b0;
	logic go = 1'b0;
	logic [7:0] len = 8'h0;
	logic [31:0] rdata;
	logic input_on, pin_o, pin_oe, drv_oe, line;
	logic [7:0] seen;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	initial forever #2.5 sys_clk = ~sys_clk;
	// Pull-up when neither end drives
	assign line = pin_oe ? pin_o : !drv_oe;
	sync_off_pin #(.PULSE_CYC(PC)) u_sync_off_pin (.sys_clk(sys_clk),
		.srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .sw_on(sw_on), .sw_off(sw_off),
		.input_on(input_on), .pin_i(line), .pin_o(pin_o), .pin_oe(pin_oe));
	sync_peer u_sync_peer (.sys_clk(sys_clk), .line(line), .go(go),
		.len(len), .drv_oe(drv_oe), .seen_q(seen));
	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		tick(1);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		tick(1);
		rd <= 1'b0;
		@(negedge sys_clk);
		chk("rdata", e, rdata);
		tick(1);
	endtask
	task automatic sw(input logic off);
		sw_on <= !off;
		sw_off <= off;
		tick(1);
		sw_on <= 1'b0;
		sw_off <= 1'b0;
		@(negedge sys_clk);
		tick(1);
	endtask
	task automatic send(input logic [7:0] n);
		len <= n;
		go <= 1'b1;
		tick(1);
		go <= 1'b0;
	endtask
	task automatic t_reset();
		rd_chk(OFS_CTRL, 32'h11);
		rd_chk(OFS_PWM_PER, 32'hc8);
		rd_chk(OFS_PWM_HI, 32'h64);
		rd_chk(OFS_STATUS, 32'h2);
		rd_chk(4'h2, 32'h0);
		chk("pin_oe", 1'b0, pin_oe);
	endtask
	task automatic t_local(input logic inv);
		wr_reg(OFS_CTRL, {25'h0, OM_TRUE, inv, FN_SYNC});
		sw(1'b0);
		sw(1'b1);
		chk("input_on", 1'b0, input_on);
		chk("pin_oe", 1'b1, pin_oe);
		chk("pin_o", inv, pin_o);
		tick(PC + 2);
		chk("pin_oe", 1'b0, pin_oe);
		if (!inv)
			chk("width", PC, seen);
	endtask
	task automatic t_remote();
		sw(1'b0);
		send(PC - 3);
		tick(PC + 6);
		chk("input_on", 1'b1, input_on);
		send(PC + 4);
		tick(2 * PC + 8);
		chk("input_on", 1'b0, input_on);
		send(PC + 4);
		tick(PC + 5);
		chk("pin_oe", 1'b0, pin_oe);
		tick(PC);
		chk("input_on", 1'b0, input_on);
	endtask
	task automatic t_in();
		wr_reg(OFS_CTRL, {25'h0, OM_TRUE, 1'b0, FN_IN});
		send(8'h0c);
		tick(4);
		chk("pin_oe", 1'b0, pin_oe);
		rd_chk(OFS_STATUS, 32'h0);
		wr_reg(OFS_CTRL, 32'hb);
		rd_chk(OFS_CTRL, 32'h1a);
		tick(8);
	endtask
	task automatic t_out();
		omode_t om;
		for (int i = 0; i < 4; i++) begin
			om = i[0] ? OM_FALSE : OM_TRUE;
			wr_reg(OFS_CTRL, {25'h0, om, i[1], FN_OUT});
			tick(2);
			chk("pin_oe", 1'b1, pin_oe);
			chk("pin_o", i[1] ^ i[0], pin_o);
		end
	endtask
	task automatic t_pwm();
		int lows;
		wr_reg(OFS_PWM_PER, 32'h4);
		for (int h = 1; h < 4; h += 2) begin
			wr_reg(OFS_PWM_HI, h);
			wr_reg(OFS_CTRL, {25'h0, OM_PWM, 1'b0, FN_OUT});
			tick(6);
			lows = 0;
			repeat (40) begin
				@(negedge sys_clk);
				lows += (pin_o === 1'b0);
			end
			chk("pwm_active", 10 * h, lows);
			tick(1);
		end
	endtask
	initial begin
		tick(4);
		srst <= 1'b0;
		tick(3);
		t_reset();
		t_local(1'b0);
		t_local(1'b1);
		wr_reg(OFS_CTRL, 32'h11);
		t_remote();
		t_in();
		t_out();
		t_pwm();
		print_verdict();
	end
endmodule
